// [hdl/ntc_regs.sv]
// Purpose: nco tuning configuration registers with paged writes and tuning-word load
// Assumes: inputs synchronous to mclk_i; page selects come from the page register
// Notes: reads return the lowest-numbered selected instance
`timescale 1ns/1ps

// Function
// RULE_01: fraction mode adds numerator over denominator step
// RULE_02: software keeps denominator nonzero, above numerator
// RULE_03: numerator writes reach selected main instances only
// RULE_04: software enables channel nco in complex modes
// RULE_05: nco enable bit gates channel modulation
// RULE_06: fraction enable bit selects modulus operation
// RULE_07: sideband bit one runs phase backwards
// RULE_08: dc tone bit feeds amplitude into nco
// RULE_09: channel accesses reach selected channels only
// RULE_10: load-on-sync waits for sync rising edge
// RULE_11: acknowledge reads one after tuning load
// RULE_12: reserved read-only bits read zero
// RULE_13: plain main mode steps by tuning word
// RULE_14: request rising edge loads pending tuning word
// RULE_15: plain channel mode steps by tuning word
// RULE_16: numerator is one 48-bit little-endian value
module ntc_regs
  import ntc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [NTC_ADDR_W-1:0] addr_i,
  input wire logic [NTC_DATA_W-1:0] wdata_i,
  output logic [NTC_DATA_W-1:0] rdata_o,
  input wire logic [NTC_NUM_MAIN-1:0] main_path_page_select_i,
  input wire logic [NTC_NUM_CHAN-1:0] chan_page_select_i,
  input wire logic sysref_i,
  input wire logic [NTC_NUM_MAIN-1:0] main_nco_fraction_enable_i,
  input wire logic [NTC_NUM_MAIN-1:0][NTC_NCO_W-1:0] main_nco_tuning_word_i,
  input wire logic [NTC_NUM_MAIN-1:0][NTC_LO_W-1:0] main_nco_mod_numerator_lo_i,
  input wire logic [NTC_NUM_MAIN-1:0][NTC_NCO_W-1:0] main_nco_mod_denominator_i,
  output logic [NTC_NUM_MAIN-1:0][NTC_NCO_W-1:0] main_nco_mod_numerator_o,
  output logic [NTC_NUM_MAIN-1:0][NTC_NCO_W-1:0] main_phase_o,
  input wire logic [NTC_NUM_CHAN-1:0][NTC_NCO_W-1:0] chan_tuning_word_i,
  input wire logic [NTC_NUM_CHAN-1:0][NTC_NCO_W-1:0] chan_nco_mod_numerator_i,
  input wire logic [NTC_NUM_CHAN-1:0][NTC_NCO_W-1:0] chan_nco_mod_denominator_i,
  input wire logic [NTC_AMP_W-1:0] dc_tone_amplitude_i,
  input wire logic [NTC_NUM_CHAN-1:0][NTC_AMP_W-1:0] chan_data_i,
  output logic [NTC_NUM_CHAN-1:0][NTC_AMP_W-1:0] chan_nco_din_o,
  output logic [NTC_NUM_CHAN-1:0] chan_nco_enable_o,
  output logic [NTC_NUM_CHAN-1:0] chan_fraction_enable_o,
  output logic [NTC_NUM_CHAN-1:0] chan_sideband_select_o,
  output logic [NTC_NUM_CHAN-1:0] chan_dc_tone_enable_o,
  output logic [NTC_NUM_CHAN-1:0] chan_tuning_load_ack_o,
  output logic [NTC_NUM_CHAN-1:0][NTC_NCO_W-1:0] chan_active_tuning_word_o,
  output logic [NTC_NUM_CHAN-1:0][NTC_NCO_W-1:0] chan_phase_o
);

  ntc_regs_t q;
  ntc_regs_t d;
  logic sref_rise;
  logic [NTC_NUM_CHAN-1:0] sync_load;
  int mi;
  int ci;

  // ************************************************************
  // read instance pick and sync edge
  // ************************************************************
  assign sref_rise = sysref_i & ~q.sysref_prev;
  assign sync_load = q.pend & {NTC_NUM_CHAN{sref_rise}}; // clear lands with the ack

  // lowest selected instance answers reads
  always_comb begin
    mi = 0;
    ci = 0;
    for (int m = NTC_NUM_MAIN - 1; m >= 0; m--) begin
      if (main_path_page_select_i[m]) begin
        mi = m;
      end
    end
    for (int c = NTC_NUM_CHAN - 1; c >= 0; c--) begin
      if (chan_page_select_i[c]) begin
        ci = c;
      end
    end
  end

  // ************************************************************
  // register next state
  // ************************************************************
  always_comb begin
    d = q;
    d.sysref_prev = sysref_i;
    // paged writes to the numerator upper bytes
    for (int m = 0; m < NTC_NUM_MAIN; m++) begin
      if (wr_en_i && main_path_page_select_i[m]) begin // see RULE_03
        case (addr_i)
          NTC_ADDR_MAIN_NUM3: d.num_hi[m][NTC_BYTE3_LSB +: NTC_DATA_W] = wdata_i; // see RULE_16
          NTC_ADDR_MAIN_NUM4: d.num_hi[m][NTC_BYTE4_LSB +: NTC_DATA_W] = wdata_i;
          NTC_ADDR_MAIN_NUM5: d.num_hi[m][NTC_BYTE5_LSB +: NTC_DATA_W] = wdata_i;
          default: d.num_hi[m] = q.num_hi[m];
        endcase
      end
    end
    for (int c = 0; c < NTC_NUM_CHAN; c++) begin
      // armed load fires on sync rising edge and restarts the nco
      if (sync_load[c]) begin // see RULE_10
        d.frequency_tuning_word[c] = chan_tuning_word_i[c];
        d.ack[c] = 1'b1; // see RULE_11
        d.pend[c] = 1'b0;
      end
      if (wr_en_i && chan_page_select_i[c]) begin // see RULE_09
        if (addr_i == NTC_ADDR_CHAN_CFG) begin
          d.cfg[c] = wdata_i[NTC_CFG_W-1:0];
        end
        if (addr_i == NTC_ADDR_CHAN_UPD) begin
          d.sync_en[c] = wdata_i[NTC_UPD_SYNC_BIT];
          d.req[c] = wdata_i[NTC_UPD_REQ_BIT];
          // only a zero-to-one request edge starts a load
          if (wdata_i[NTC_UPD_REQ_BIT] && !q.req[c]) begin // see RULE_14
            d.ack[c] = q.pend[c] && sref_rise; // set wins over clear
            if (wdata_i[NTC_UPD_SYNC_BIT]) begin
              d.pend[c] = 1'b1; // see RULE_10
            end else begin
              d.frequency_tuning_word[c] = chan_tuning_word_i[c];
              d.ack[c] = 1'b1; // see RULE_11
              d.pend[c] = 1'b0;
            end
          end
        end
      end
      // dc test level or live data into the nco
      d.din[c] = q.cfg[c][NTC_CFG_DC_BIT] ? dc_tone_amplitude_i : chan_data_i[c]; // see RULE_08
    end
    // registered read data, unmapped reads zero
    if (rd_en_i) begin
      case (addr_i)
        NTC_ADDR_MAIN_NUM3: d.rdata = q.num_hi[mi][NTC_BYTE3_LSB +: NTC_DATA_W];
        NTC_ADDR_MAIN_NUM4: d.rdata = q.num_hi[mi][NTC_BYTE4_LSB +: NTC_DATA_W];
        NTC_ADDR_MAIN_NUM5: d.rdata = q.num_hi[mi][NTC_BYTE5_LSB +: NTC_DATA_W];
        NTC_ADDR_CHAN_CFG: d.rdata = {1'b0, q.cfg[ci]}; // see RULE_12
        NTC_ADDR_CHAN_UPD: d.rdata = {5'h00, q.sync_en[ci], q.ack[ci], q.req[ci]}; // see RULE_12
        default: d.rdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign chan_tuning_load_ack_o = q.ack;
  assign chan_nco_din_o = q.din;
  assign chan_active_tuning_word_o = q.frequency_tuning_word;

  // ************************************************************
  // main path oscillators
  // ************************************************************
  for (genvar m = 0; m < NTC_NUM_MAIN; m++) begin : g_main
    assign main_nco_mod_numerator_o[m] = {q.num_hi[m], main_nco_mod_numerator_lo_i[m]}; // see RULE_16
    ntc_nco_acc u_acc (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .run_i(1'b1),
      .clr_i(1'b0),
      .frac_en_i(main_nco_fraction_enable_i[m]),
      .flip_i(1'b0),
      .ftw_i(main_nco_tuning_word_i[m]),
      .num_i(main_nco_mod_numerator_o[m]),
      .den_i(main_nco_mod_denominator_i[m]),
      .phase_o(main_phase_o[m])
    );
    a_main_paging: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_03
      wr_en_i && !main_path_page_select_i[m] |=> $stable(q.num_hi[m]))
      else $error("unselected main instance written");
    a_numer_pack: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_16
      wr_en_i && main_path_page_select_i[m] && addr_i == NTC_ADDR_MAIN_NUM5
        |=> main_nco_mod_numerator_o[m][NTC_NCO_W-1 -: NTC_DATA_W] == $past(wdata_i))
      else $error("numerator top byte misplaced");
  end

  // ************************************************************
  // channel oscillators and controls
  // ************************************************************
  for (genvar c = 0; c < NTC_NUM_CHAN; c++) begin : g_chan
    assign chan_nco_enable_o[c] = q.cfg[c][NTC_CFG_NCO_EN_BIT];
    assign chan_fraction_enable_o[c] = q.cfg[c][NTC_CFG_FRAC_BIT];
    assign chan_sideband_select_o[c] = q.cfg[c][NTC_CFG_SIDEBAND_BIT];
    assign chan_dc_tone_enable_o[c] = q.cfg[c][NTC_CFG_DC_BIT];
    // enable gates stepping, fraction and sideband steer it
    ntc_nco_acc u_acc (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .run_i(q.cfg[c][NTC_CFG_NCO_EN_BIT]), // see RULE_05
      .clr_i(sync_load[c]), // see RULE_10
      .frac_en_i(q.cfg[c][NTC_CFG_FRAC_BIT]), // see RULE_06
      .flip_i(q.cfg[c][NTC_CFG_SIDEBAND_BIT]), // see RULE_07
      .ftw_i(q.frequency_tuning_word[c]),
      .num_i(chan_nco_mod_numerator_i[c]),
      .den_i(chan_nco_mod_denominator_i[c]),
      .phase_o(chan_phase_o[c])
    );
    a_nco_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_05
      !q.cfg[c][NTC_CFG_NCO_EN_BIT] && !sync_load[c] |=> $stable(chan_phase_o[c]))
      else $error("disabled channel nco moved");
    a_chan_paging: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_09
      wr_en_i && !chan_page_select_i[c] && !sref_rise |=> $stable(q.cfg[c]) && $stable(q.frequency_tuning_word[c]))
      else $error("unselected channel written");
    a_sync_wait: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_10
      q.pend[c] && !sref_rise && !wr_en_i |=> $stable(q.frequency_tuning_word[c]) && !q.ack[c])
      else $error("load before sync edge");
    a_sync_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_10
      q.pend[c] && sref_rise |=> q.ack[c] && chan_phase_o[c] == '0
        && q.frequency_tuning_word[c] == $past(chan_tuning_word_i[c]))
      else $error("sync load missing");
    a_req_edge: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_14
      wr_en_i && chan_page_select_i[c] && addr_i == NTC_ADDR_CHAN_UPD
        && wdata_i[NTC_UPD_REQ_BIT] && !wdata_i[NTC_UPD_SYNC_BIT] && !q.req[c]
        |=> q.ack[c] && q.frequency_tuning_word[c] == $past(chan_tuning_word_i[c]))
      else $error("request edge did not load");
    a_ack_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_11
      $rose(q.ack[c]) |-> $past(q.pend[c] && sref_rise) || $past(wr_en_i && chan_page_select_i[c]))
      else $error("acknowledge without load");
    a_dc_feed: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_08
      q.cfg[c][NTC_CFG_DC_BIT] |=> chan_nco_din_o[c] == $past(dc_tone_amplitude_i))
      else $error("dc tone not fed");
  end

  a_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_12
    rd_en_i && (addr_i == NTC_ADDR_CHAN_UPD || addr_i == NTC_ADDR_CHAN_CFG)
      |=> rdata_o[NTC_DATA_W-1] == 1'b0
        && ($past(addr_i) != NTC_ADDR_CHAN_UPD || rdata_o[NTC_DATA_W-1:NTC_UPD_SYNC_BIT+1] == '0))
    else $error("reserved bits nonzero");

  c_sync_load: cover property (@(posedge mclk_i) disable iff (!rst_n_i) |sync_load);
  c_now_load: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_en_i && addr_i == NTC_ADDR_CHAN_UPD && chan_page_select_i[0] ##1 $rose(q.ack[0]));
  c_dc_tone: cover property (@(posedge mclk_i) disable iff (!rst_n_i) chan_dc_tone_enable_o[0]);

endmodule

// [common/ntc_pkg.sv]
// Purpose: shared constants and state types for the nco tuning configuration block
// Assumes: byte-wide register port, page selects supplied from the page register outside
// Notes: all registers reset to zero

package ntc_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int NTC_NUM_MAIN = 2;
  localparam int NTC_NUM_CHAN = 6;
  localparam int NTC_NCO_W = 48;
  localparam int NTC_ADDR_W = 12;
  localparam int NTC_DATA_W = 8;
  localparam int NTC_AMP_W = 16;
  localparam int NTC_LO_W = 24;
  localparam int NTC_HI_W = 24;
  localparam int NTC_CFG_W = 7;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [NTC_ADDR_W-1:0] NTC_ADDR_MAIN_NUM3 = 12'h12d;
  localparam logic [NTC_ADDR_W-1:0] NTC_ADDR_MAIN_NUM4 = 12'h12e;
  localparam logic [NTC_ADDR_W-1:0] NTC_ADDR_MAIN_NUM5 = 12'h12f;
  localparam logic [NTC_ADDR_W-1:0] NTC_ADDR_CHAN_CFG = 12'h130;
  localparam logic [NTC_ADDR_W-1:0] NTC_ADDR_CHAN_UPD = 12'h131;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int NTC_CFG_NCO_EN_BIT = 6;
  localparam int NTC_CFG_FRAC_BIT = 2;
  localparam int NTC_CFG_SIDEBAND_BIT = 1;
  localparam int NTC_CFG_DC_BIT = 0;
  localparam int NTC_UPD_SYNC_BIT = 2;
  localparam int NTC_UPD_ACK_BIT = 1;
  localparam int NTC_UPD_REQ_BIT = 0;
  localparam int NTC_BYTE3_LSB = 0;
  localparam int NTC_BYTE4_LSB = 8;
  localparam int NTC_BYTE5_LSB = 16;

  // ************************************************************
  // state types
  // ************************************************************
  typedef struct packed {
    logic [NTC_NCO_W-1:0] acc;
    logic [NTC_NCO_W-1:0] frac;
  } ntc_acc_t;

  typedef struct packed {
    logic [NTC_NUM_MAIN-1:0][NTC_HI_W-1:0] num_hi;
    logic [NTC_NUM_CHAN-1:0][NTC_CFG_W-1:0] cfg;
    logic [NTC_NUM_CHAN-1:0] sync_en;
    logic [NTC_NUM_CHAN-1:0] ack;
    logic [NTC_NUM_CHAN-1:0] req;
    logic [NTC_NUM_CHAN-1:0] pend;
    logic [NTC_NUM_CHAN-1:0][NTC_NCO_W-1:0] frequency_tuning_word;
    logic [NTC_NUM_CHAN-1:0][NTC_AMP_W-1:0] din;
    logic sysref_prev;
    logic [NTC_DATA_W-1:0] rdata;
  } ntc_regs_t;

endpackage

// [hdl/ntc_nco_acc.sv]
// Purpose: phase accumulator with optional fractional modulus
// Assumes: denominator nonzero when fraction mode is used
// Notes: flip runs the phase backwards, giving the lower sideband
`timescale 1ns/1ps

module ntc_nco_acc
  import ntc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic clr_i,
  input wire logic frac_en_i,
  input wire logic flip_i,
  input wire logic [NTC_NCO_W-1:0] ftw_i,
  input wire logic [NTC_NCO_W-1:0] num_i,
  input wire logic [NTC_NCO_W-1:0] den_i,
  output logic [NTC_NCO_W-1:0] phase_o
);

  ntc_acc_t q;
  ntc_acc_t d;
  logic [NTC_NCO_W:0] sum;
  logic carry;
  logic [NTC_NCO_W-1:0] step;

  // ************************************************************
  // fractional carry and step
  // ************************************************************
  assign sum = {1'b0, q.frac} + {1'b0, num_i};
  assign carry = frac_en_i && (sum >= {1'b0, den_i}); // see RULE_01
  assign step = ftw_i + {{(NTC_NCO_W-1){1'b0}}, carry};

  // next state of the accumulator
  always_comb begin
    d = q;
    if (clr_i) begin
      d = '0;
    end else if (run_i) begin
      if (!frac_en_i) begin
        d.frac = '0; // see RULE_13 see RULE_15
      end else if (carry) begin
        d.frac = NTC_NCO_W'(sum - {1'b0, den_i});
      end else begin
        d.frac = sum[NTC_NCO_W-1:0];
      end
      d.acc = flip_i ? q.acc - step : q.acc + step; // see RULE_07
    end
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign phase_o = q.acc;

  // ************************************************************
  // checks
  // ************************************************************
  a_plain_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_13
    run_i && !clr_i && !frac_en_i && !flip_i |=> phase_o == NTC_NCO_W'($past(phase_o) + $past(ftw_i)))
    else $error("plain step wrong");
  a_frac_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_01
    run_i && !clr_i && frac_en_i && !flip_i
      |=> NTC_NCO_W'(phase_o - $past(phase_o) - $past(ftw_i)) <= NTC_NCO_W'(1))
    else $error("fraction step wrong");
  a_flip_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_07
    run_i && !clr_i && !frac_en_i && flip_i |=> phase_o == NTC_NCO_W'($past(phase_o) - $past(ftw_i)))
    else $error("lower sideband step wrong");
  c_frac_carry: cover property (@(posedge mclk_i) disable iff (!rst_n_i) run_i && carry);

endmodule

// [tb/nco_tuning_config_regs_bench.sv]
// Purpose: self-checking bench for the nco tuning configuration registers
// Assumes: byte register port and page selects driven by the bench
// Notes: reference model is kept in arrays and bit vectors inside the bench
`timescale 1ns/1ps

module nco_tuning_config_regs_bench
  import ntc_pkg::*;
;
  logic mclk_i, rst_n_i, wr_en_i, rd_en_i, sysref_i;
  logic [NTC_ADDR_W-1:0] addr_i;
  logic [NTC_DATA_W-1:0] wdata_i, rdata_o;
  logic [NTC_NUM_MAIN-1:0] mpage, mfrac;
  logic [NTC_NUM_CHAN-1:0] cpage, nco_en, frac_en, side, dc_en, ack;
  logic [NTC_NUM_MAIN-1:0][NTC_NCO_W-1:0] mtw, mden, mnum, mph;
  logic [NTC_NUM_MAIN-1:0][NTC_LO_W-1:0] mlo;
  logic [NTC_NUM_CHAN-1:0][NTC_NCO_W-1:0] ctw, cnum, cden, cact, cph;
  logic [NTC_AMP_W-1:0] amp;
  logic [NTC_NUM_CHAN-1:0][NTC_AMP_W-1:0] cdat, cdin;
  logic [7:0] cfg_m [6];
  logic [23:0] hi_m [2];
  logic [5:0] ack_m, req_m, syn_m, arm_m;
  logic [47:0] act_m [6];
  logic [7:0] rv;
  integer seed = 71716, bad_count = 0, tests_run = 0, cyc = 0;

  // ************************************************************
  // clock, timeout, design
  // ************************************************************
  // free-running 125 mhz clock
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  // cut a hang short
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      finish_test();
    end
  end

  ntc_regs uut (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .rdata_o(rdata_o),
    .main_path_page_select_i(mpage),
    .chan_page_select_i(cpage),
    .sysref_i(sysref_i),
    .main_nco_fraction_enable_i(mfrac),
    .main_nco_tuning_word_i(mtw),
    .main_nco_mod_numerator_lo_i(mlo),
    .main_nco_mod_denominator_i(mden),
    .main_nco_mod_numerator_o(mnum),
    .main_phase_o(mph),
    .chan_tuning_word_i(ctw),
    .chan_nco_mod_numerator_i(cnum),
    .chan_nco_mod_denominator_i(cden),
    .dc_tone_amplitude_i(amp),
    .chan_data_i(cdat),
    .chan_nco_din_o(cdin),
    .chan_nco_enable_o(nco_en),
    .chan_fraction_enable_o(frac_en),
    .chan_sideband_select_o(side),
    .chan_dc_tone_enable_o(dc_en),
    .chan_tuning_load_ack_o(ack),
    .chan_active_tuning_word_o(cact),
    .chan_phase_o(cph)
  );

  // ************************************************************
  // tasks and model
  // ************************************************************
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic int low(input logic [5:0] p);
    low = 0;
    for (int i = 5; i >= 0; i--) if (p[i]) low = i;
  endfunction

  function automatic logic [47:0] ph(input int w);
    ph = (w < 6) ? cph[w] : mph[w-6];
  endfunction

  // one write, then the model takes the same write
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] mp,
                    input logic [5:0] cp);
    @(posedge mclk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    mpage <= mp;
    cpage <= cp;
    for (int i = 0; i < 2; i++) begin
      if (mp[i] && a >= 12'h12d && a <= 12'h12f) hi_m[i][8*(a-12'h12d) +: 8] = d;
    end
    for (int i = 0; i < 6; i++) begin
      if (cp[i] && a == 12'h130) cfg_m[i] = d & 8'h7f;
      if (cp[i] && a == 12'h131) begin
        if (d[0] && !req_m[i]) begin
          ack_m[i] = !d[2];
          arm_m[i] = d[2];
          if (!d[2]) act_m[i] = ctw[i];
        end
        req_m[i] = d[0];
        syn_m[i] = d[2];
      end
    end
    @(posedge mclk_i);
    wr_en_i <= 1'b0;
  endtask

  // one read, compared with the lowest selected instance of the model
  task automatic rd(input logic [11:0] a, input logic [5:0] cp, input logic [1:0] mp);
    logic [7:0] e;
    int l;
    @(posedge mclk_i);
    rd_en_i <= 1'b1;
    addr_i <= a;
    mpage <= mp;
    cpage <= cp;
    @(posedge mclk_i);
    rd_en_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    l = low(cp);
    case (a)
      12'h12d, 12'h12e, 12'h12f: e = hi_m[low({4'h0, mp})][8*(a-12'h12d) +: 8];
      12'h130: e = cfg_m[l];
      12'h131: e = {5'h00, syn_m[l], ack_m[l], req_m[l]};
      default: e = 8'h00;
    endcase
    chk("rdata", e, rdata_o);
  endtask

  // numerator, cfg bits, nco din, ack and active word of each instance against the model
  task automatic outs();
    @(posedge mclk_i);
    #1;
    for (int i = 0; i < 2; i++) chk("numerator", {hi_m[i], mlo[i]}, mnum[i]);
    for (int i = 0; i < 6; i++) begin
      chk("cfg_bits", {cfg_m[i][6], cfg_m[i][2:0]}, {nco_en[i], frac_en[i], side[i], dc_en[i]});
      chk("nco_din", cfg_m[i][0] ? amp : cdat[i], cdin[i]);
      chk("ack", ack_m[i], ack[i]);
      chk("active_word", act_m[i], cact[i]);
    end
  endtask

  // phase advance over n cycles
  task automatic span(input int w, input int n, input logic [47:0] e);
    logic [47:0] p;
    repeat (2) @(posedge mclk_i);
    #1;
    p = ph(w);
    repeat (n) @(posedge mclk_i);
    #1;
    chk("phase_step", e, ph(w) - p);
  endtask

  task automatic new_words();
    @(posedge mclk_i);
    for (int i = 0; i < 6; i++) ctw[i] <= 48'({$random(seed), $random(seed)});
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst_n_i = 1'b0;
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    sysref_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    mpage = '0;
    cpage = '0;
    mfrac = 2'b10;
    mlo = {24'h000001, 24'h00a5c3};
    mden = {2{48'h000000000004}};
    cnum = {6{48'h000000000001}};
    cden = {6{48'h000000000004}};
    amp = 16'($random(seed));
    for (int i = 0; i < 2; i++) mtw[i] = 48'({$random(seed), $random(seed)});
    for (int i = 0; i < 6; i++) begin
      ctw[i] = 48'({$random(seed), $random(seed)});
      cdat[i] = 16'($random(seed));
      cfg_m[i] = 8'h00;
      act_m[i] = 48'h0;
    end
    hi_m[0] = 24'h0;
    hi_m[1] = 24'h0;
    {ack_m, req_m, syn_m, arm_m} = '0;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    wr(12'h132, 8'hff, 2'h3, 6'h3f);
    for (int a = 'h12d; a <= 'h132; a++) rd(a[11:0], 6'h01, 2'h1);
    for (int k = 0; k < 3; k++) begin
      wr(12'h12d + k[11:0], 8'($random(seed)), 2'h1, 6'h00);
      rd(12'h12d + k[11:0], 6'h01, 2'h1);
    end
    wr(12'h12f, 8'h5a, 2'h0, 6'h3f);
    rd(12'h12f, 6'h01, 2'h2);
    for (int k = 0; k < 6; k++) begin
      rv = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
      wr(12'h130, rv, 2'h0, (k < 2) ? 6'h3f : 6'($random(seed)));
      rd(12'h130, 6'($random(seed)) | 6'h20, 2'h0);
      outs();
    end
    wr(12'h131, 8'h00, 2'h0, 6'h3f);
    wr(12'h131, 8'hf9, 2'h0, 6'h3f);
    rd(12'h131, 6'h3f, 2'h0);
    outs();
    new_words();
    wr(12'h131, 8'h01, 2'h0, 6'h3f);
    outs();
    wr(12'h130, 8'h40, 2'h0, 6'h01);
    span(0, 1, act_m[0]);
    wr(12'h130, 8'h42, 2'h0, 6'h01);
    span(0, 1, -act_m[0]);
    wr(12'h130, 8'h44, 2'h0, 6'h01);
    span(0, 4, 4 * act_m[0] + 48'h1);
    wr(12'h130, 8'h00, 2'h0, 6'h01);
    span(0, 2, 48'h0);
    span(6, 3, 3 * mtw[0]);
    span(7, 4, 4 * mtw[1] + 48'h1);
    wr(12'h131, 8'h00, 2'h0, 6'h02);
    new_words();
    wr(12'h131, 8'h05, 2'h0, 6'h02);
    rd(12'h131, 6'h02, 2'h0);
    @(posedge mclk_i);
    sysref_i <= 1'b1;
    #1;
    chk("ack_wait", {47'h0, ~arm_m[1]}, ack[1]);
    @(posedge mclk_i);
    #1;
    ack_m[1] = 1'b1;
    act_m[1] = ctw[1];
    arm_m = '0;
    chk("sync_phase", 48'h0, cph[1]);
    outs();
    @(posedge mclk_i);
    sysref_i <= 1'b0;
    finish_test();
  end
endmodule
